// ===== src/rot_consts.vh
// Constants for the byte rotate execution unit.
// Assumes inclusion by bare name from the design files under src/.
`ifndef ROT_CONSTS_VH
`define ROT_CONSTS_VH
`define OPC_RLN        6'h11
`define OPC_RRC        6'h0c
`define OPC_HI         15
`define OPC_LO         10
`define BIT_DEST       9
`define BIT_ACC        8
`define ACC_SPLIT      8'h80
`define IDX_LIMIT      8'h5f
`define ACC_HI_BANK    4'hf
`define PH_DECODE      2'h0
`define PH_READ        2'h1
`define PH_PROCESS     2'h2
`define PH_WRITE       2'h3
`define RST_BYTE       8'h00
`define RST_ADDR       12'h000
`define ZERO_BYTE      8'h00
`define FILE_HI        7
`define FILE_LO        0
`define SIGN_BIT       7
`define ACC_LO_BANK    4'h0
`endif

// ===== src/rot_alu.v
// Combinational rotate unit for the two rotate operations.
// Assumes the caller registers operand, carry and select around it.
module rot_alu (
  input  wire       right_sel,
  input  wire [7:0] operand,
  input  wire       carry_in,
  output reg  [7:0] result,
  output reg        carry_out
);
  always @* begin
    if (right_sel) begin
      result    = {carry_in, operand[7:1]};
      carry_out = operand[0];
    end else begin
      result    = {operand[6:0], operand[7]};
      carry_out = carry_in;
    end
  end
endmodule

// ===== src/rotate_exec.v
// Execution datapath for left rotate without carry and right rotate through carry.
// Assumes a data memory port with combinational read data and a one-cycle write
// strobe, and instruction words from logic on the same clock.
`include "rot_consts.vh"

module rotate_exec (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        instr_valid,
  input  wire [15:0] instr,
  input  wire [3:0]  bank_select_register,
  input  wire        ext_set_en,
  input  wire [11:0] index_base,
  input  wire [7:0]  mem_rdata,
  output reg  [11:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  output reg         mem_we,
  output reg  [7:0]  w_acc,
  output reg         flag_c,
  output reg         flag_n,
  output reg         flag_z,
  output reg  [1:0]  phase,
  output reg         busy,
  output reg         illegal
);

  // ----------------------------------------------------------------
  // Registers and the rotate unit
  // ----------------------------------------------------------------
  reg        right_q;
  reg        right_d;
  reg        dest_q;
  reg        dest_d;
  reg [7:0]  opnd_q;
  reg [7:0]  opnd_d;
  reg [7:0]  res_q;
  reg [7:0]  res_d;
  reg        cout_q;
  reg        cout_d;
  reg [1:0]  phase_d;
  reg        busy_d;
  reg        illegal_d;
  reg [11:0] mem_addr_d;
  reg [7:0]  mem_wdata_d;
  reg        mem_we_d;
  reg [7:0]  w_acc_d;
  reg        flag_c_d;
  reg        flag_n_d;
  reg        flag_z_d;
  reg [11:0] addr_d;
  wire [7:0] alu_res;
  wire       alu_c;
  wire [5:0] opc;
  wire [7:0] file_sel;
  wire       is_left;
  wire       is_right;
  wire       known_op;
  wire       take;

  rot_alu u_alu (
    .right_sel (right_q),
    .operand   (opnd_q),
    .carry_in  (flag_c),
    .result    (alu_res),
    .carry_out (alu_c)
  );

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  assign opc      = instr[`OPC_HI:`OPC_LO];
  assign file_sel = instr[`FILE_HI:`FILE_LO];
  assign is_left  = (opc == `OPC_RLN);
  assign is_right = (opc == `OPC_RRC);
  assign known_op = is_left | is_right;
  // Words offered outside the decode phase are ignored, never queued.
  assign take     = instr_valid & known_op & (phase == `PH_DECODE);

  // ----------------------------------------------------------------
  // Operand address formation
  // ----------------------------------------------------------------
  always @* begin
    if (instr[`BIT_ACC]) begin
      addr_d = {bank_select_register, file_sel};
    end else if (ext_set_en && (file_sel <= `IDX_LIMIT)) begin
      addr_d = index_base + {4'h0, file_sel};
    end else if (file_sel < `ACC_SPLIT) begin
      addr_d = {`ACC_LO_BANK, file_sel};
    end else begin
      addr_d = {`ACC_HI_BANK, file_sel};
    end
  end

  // ----------------------------------------------------------------
  // Four-phase sequence
  // ----------------------------------------------------------------
  always @* begin
    phase_d   = phase;
    busy_d    = busy;
    illegal_d = 1'h0;
    case (phase)
      `PH_DECODE: begin
        if (take) begin
          phase_d = `PH_READ;
          busy_d  = 1'h1;
        end
        illegal_d = instr_valid & ~known_op;
      end
      `PH_READ: begin
        phase_d = `PH_PROCESS;
      end
      `PH_PROCESS: begin
        phase_d = `PH_WRITE;
      end
      `PH_WRITE: begin
        phase_d = `PH_DECODE;
        busy_d  = 1'h0;
      end
      default: begin
        phase_d = `PH_DECODE;
        busy_d  = 1'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Operand and result path
  // ----------------------------------------------------------------
  always @* begin
    right_d = right_q;
    dest_d  = dest_q;
    opnd_d  = opnd_q;
    res_d   = res_q;
    cout_d  = cout_q;
    if (take) begin
      right_d = is_right;
      dest_d  = instr[`BIT_DEST];
    end
    if (phase == `PH_READ) begin
      opnd_d = mem_rdata;
    end
    if (phase == `PH_PROCESS) begin
      res_d  = alu_res;
      cout_d = alu_c;
    end
  end

  // ----------------------------------------------------------------
  // Destination and status updates
  // ----------------------------------------------------------------
  always @* begin
    mem_addr_d  = mem_addr;
    mem_wdata_d = mem_wdata;
    mem_we_d    = 1'h0;
    w_acc_d     = w_acc;
    flag_c_d    = flag_c;
    flag_n_d    = flag_n;
    flag_z_d    = flag_z;
    if (take) begin
      mem_addr_d = addr_d;
    end
    if (phase == `PH_WRITE) begin
      if (dest_q) begin
        mem_wdata_d = res_q;
        mem_we_d    = 1'h1;
      end else begin
        w_acc_d = res_q;
      end
      flag_c_d = cout_q;
      flag_n_d = res_q[`SIGN_BIT];
      flag_z_d = (res_q == `ZERO_BYTE);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      phase   <= `PH_DECODE;
      busy    <= 1'h0;
      illegal <= 1'h0;
    end else begin
      phase   <= phase_d;
      busy    <= busy_d;
      illegal <= illegal_d;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      right_q <= 1'h0;
      dest_q  <= 1'h1;
      opnd_q  <= `RST_BYTE;
      res_q   <= `RST_BYTE;
      cout_q  <= 1'h0;
    end else begin
      right_q <= right_d;
      dest_q  <= dest_d;
      opnd_q  <= opnd_d;
      res_q   <= res_d;
      cout_q  <= cout_d;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      mem_addr  <= `RST_ADDR;
      mem_wdata <= `RST_BYTE;
      mem_we    <= 1'h0;
      w_acc     <= `RST_BYTE;
      flag_c    <= 1'h0;
      flag_n    <= 1'h0;
      flag_z    <= 1'h0;
    end else begin
      mem_addr  <= mem_addr_d;
      mem_wdata <= mem_wdata_d;
      mem_we    <= mem_we_d;
      w_acc     <= w_acc_d;
      flag_c    <= flag_c_d;
      flag_n    <= flag_n_d;
      flag_z    <= flag_z_d;
    end
  end

endmodule

// ===== sim/rot_sva.sv
// Port checker for the rotate execution unit.
// Assumes it is bound onto every rotate_exec instance.
module rot_sva (
  input wire        clk,
  input wire        rst_n,
  input wire        instr_valid,
  input wire [15:0] instr,
  input wire [3:0]  bank_select_register,
  input wire        ext_set_en,
  input wire [11:0] index_base,
  input wire [7:0]  mem_rdata,
  input wire [11:0] mem_addr,
  input wire [7:0]  mem_wdata,
  input wire        mem_we,
  input wire [7:0]  w_acc,
  input wire        flag_c,
  input wire        flag_n,
  input wire        flag_z,
  input wire [1:0]  phase,
  input wire        busy,
  input wire        illegal
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] op_q;
  logic [5:0] opc_q;
  logic       c_q;
  wire go = !phase && instr_valid && (instr[15:10] == 6'h11 || instr[15:10] == 6'h0c);
  wire [7:0] res = opc_q == 6'h11 ? {op_q[6:0], op_q[7]} : {c_q, op_q[7:1]};
  wire [11:0] acc_exp = (ext_set_en && instr[7:0] <= 8'h5f) ?
    index_base + {4'h0, instr[7:0]} : {{4{instr[7]}}, instr[7:0]};
  always @(posedge clk) if (phase == 2'h1) op_q <= mem_rdata;
  always @(posedge clk) if (phase == 2'h1) c_q <= flag_c;
  always @(posedge clk) if (go) opc_q <= instr[15:10];
  a_phase_walk: assert property (go |=> phase == 1 ##1 phase == 2 ##1 phase == 3 ##1 !phase)
    else $error("phase order");
  a_busy_span: assert property (go |=> busy[*3] ##1 !busy) else $error("busy span");
  a_file_dest: assert property (go && instr[9] |=> ##2 !mem_we ##1 mem_we && mem_wdata == res)
    else $error("file write");
  a_acc_dest: assert property (go && !instr[9] |=> ##3 !mem_we && w_acc == res)
    else $error("acc write");
  a_left_carry: assert property ($past(phase) == 3 && opc_q == 6'h11 |-> $stable(flag_c))
    else $error("left carry");
  a_right_carry: assert property ($past(phase) == 3 && opc_q == 6'h0c |-> flag_c == op_q[0])
    else $error("right carry");
  a_nz_flags: assert property ($past(phase) == 3 |-> flag_n == res[7] && flag_z == !res)
    else $error("n z flags");
  a_bank_addr: assert property (go && instr[8] |=>
    mem_addr == {$past(bank_select_register), $past(instr[7:0])}) else $error("bank addr");
  a_access_addr: assert property (go && !instr[8] |=> mem_addr == $past(acc_exp))
    else $error("access addr");
  a_busy_refuse: assert property (phase != 2'h0 |=> !illegal) else $error("refused op");
  a_bad_opcode: assert property (!phase && instr_valid && !go |=> illegal) else $error("bad op");
endmodule
bind rotate_exec rot_sva rot_sva_u (.*);

// ===== sim/testbench.sv
// Self-checking bench for the rotate execution unit.
// Assumes a combinational memory model answering mem_addr.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, instr_valid = 0, ext_set_en = 0;
  logic [15:0] instr = 16'h0000;
  logic [3:0]  bank_select_register = 4'h0;
  logic [11:0] index_base = 12'h000;
  logic [7:0]  mem [0:4095];
  wire  [11:0] mem_addr;
  wire  [7:0]  mem_wdata, w_acc;
  wire  [1:0]  phase;
  wire         mem_we, flag_c, flag_n, flag_z, busy, illegal;
  wire  [7:0]  mem_rdata = mem[mem_addr];
  int          failures = 0, check_count = 0;
  rotate_exec dut_u (
    .clk                  (clk),
    .rst_n                (rst_n),
    .instr_valid          (instr_valid),
    .instr                (instr),
    .bank_select_register (bank_select_register),
    .ext_set_en           (ext_set_en),
    .index_base           (index_base),
    .mem_rdata            (mem_rdata),
    .mem_addr             (mem_addr),
    .mem_wdata            (mem_wdata),
    .mem_we               (mem_we),
    .w_acc                (w_acc),
    .flag_c               (flag_c),
    .flag_n               (flag_n),
    .flag_z               (flag_z),
    .phase                (phase),
    .busy                 (busy),
    .illegal              (illegal)
  );
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;
  task chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task op(input logic [15:0] i);
    @(negedge clk) instr_valid = 1'h1;
    instr = i;
    @(negedge clk) instr_valid = 1'h0;
    repeat (4) @(negedge clk);
  endtask
  task left_test;
    mem[12'h312] = 8'hab;
    bank_select_register = 4'h3;
    op({6'h11, 2'h3, 8'h12});
    chk(mem[12'h312], 8'h57);
    chk(flag_c, 8'h00);
    $display("left done");
  endtask
  task right_test;
    mem[12'hf90] = 8'he7;
    op({6'h0c, 2'h0, 8'h90});
    chk(w_acc, 8'h73);
    chk(flag_c, 8'h01);
    op({6'h0c, 2'h0, 8'h90});
    chk(w_acc, 8'hf3);
    chk(flag_n, 8'h01);
    chk(mem[12'hf90], 8'he7);
    $display("right done");
  endtask
  task index_test;
    ext_set_en = 1'h1;
    index_base = 12'h200;
    mem[12'h210] = 8'h80;
    op({6'h11, 2'h2, 8'h10});
    chk(mem[12'h210], 8'h01);
    chk(flag_c, 8'h01);
    $display("index done");
  endtask
  task access_test;
    ext_set_en = 1'h0;
    mem[12'h005] = 8'h00;
    op({6'h11, 2'h0, 8'h05});
    chk(w_acc, 8'h00);
    chk(flag_z, 8'h01);
    ext_set_en = 1'h1;
    mem[12'h060] = 8'h01;
    op({6'h0c, 2'h2, 8'h60});
    chk(mem[12'h060], 8'h80);
    chk(flag_z, 8'h00);
    $display("access done");
  endtask
  task bad_test;
    @(negedge clk) instr_valid = 1'h1;
    instr = 16'hffff;
    @(negedge clk) instr_valid = 1'h0;
    chk(illegal, 8'h01);
    $display("bad done");
  endtask
  task results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #3000;
    failures++;
    results;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    left_test;
    right_test;
    index_test;
    access_test;
    bad_test;
    results;
  end
endmodule
